//--- src/core_perf_event_counting.sv
// Core performance event counter with thermal trip throttle
//
// Contract
// - Code 3BH counts each rise above trip
// - Throttle on trip, recheck every millisecond
// - 3CH/00H counts core cycles while unhalted
// - 3CH/01H counts bus cycles while unhalted
// - 3CH/02H counts unhalted bus cycles, other halted
// - 40H counts cacheable unlocked reads, state filtered
// - 41H counts cacheable unlocked writes, state filtered
// - 42H counts cacheable locked reads, state filtered
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "perf_regs.svh"

module core_perf_event_counting #(
    parameter int CNT_W        = 32,
    parameter int SAMPLE_CYCLES = `TRIP_SAMPLE_CYCLES
) (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    // Register port
    input  wire logic [`ADDR_W-1:0]   reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [31:0]               reg_rdata,
    // Core status
    input  wire logic                 temp_above_trip,
    input  wire logic                 core_halted,
    input  wire logic                 other_core_halted,
    input  wire logic                 bus_clk_tick,
    // First-level data cache activity
    input  wire logic                 l1_read,
    input  wire logic                 l1_write,
    input  wire logic                 l1_locked,
    input  wire perf_pkg::line_state_t l1_line_state,
    // Throttle request to clock and voltage control
    output logic                      throttle_req
);
    import perf_pkg::*;

    localparam int TICK_W = $clog2(SAMPLE_CYCLES + 1);

    logic [31:0]      evt_sel_r;
    logic [CNT_W-1:0] count_r;
    logic             temp_prev_r;
    logic [TICK_W-1:0] tick_cnt_r;
    logic             ms_tick_r;
    thermal_state_t   th_state_r;
    logic [31:0]      rdata_nxt;

    wire logic [7:0] sel_code  = evt_sel_r[`SEL_CODE_LSB +: 8];
    wire logic [7:0] sel_umask = evt_sel_r[`SEL_UMASK_LSB +: 8];
    wire logic       sel_en    = evt_sel_r[`SEL_ENABLE_BIT];
    wire logic       trip_rise = temp_above_trip & ~temp_prev_r;
    wire logic       wr_sel    = reg_wr && (reg_addr == `OFS_EVT_SEL);
    wire logic       wr_cnt    = reg_wr && (reg_addr == `OFS_COUNT);
    // Low umask nibble picks the line states that qualify a cache event
    wire logic       state_hit = |(l1_line_state & sel_umask[3:0]);

    // Event match: one source per code, so at most one occurrence a cycle
    logic inc;
    always_comb begin
        inc = 1'b0;
        if (sel_en) begin
            unique case (sel_code)
                `EVT_THERMAL_TRIP: inc = trip_rise;
                `EVT_UNHALTED: begin
                    if (sel_umask == `UM_CORE_CYCLES) begin
                        inc = ~core_halted;
                    end else if (sel_umask == `UM_BUS_CYCLES) begin
                        inc = bus_clk_tick & ~core_halted;
                    end else if (sel_umask == `UM_SOLO_BUS) begin
                        inc = bus_clk_tick & ~core_halted & other_core_halted;
                    end
                end
                `EVT_L1_READ:      inc = l1_read & ~l1_locked & state_hit;
                `EVT_L1_WRITE:     inc = l1_write & ~l1_locked & state_hit;
                `EVT_L1_LOCK_READ: inc = l1_read & l1_locked & state_hit;
                default:           inc = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            evt_sel_r <= `SEL_RESET;
        end else if (wr_sel) begin
            evt_sel_r <= reg_wdata;
        end
    end

    // Software load wins over a same-cycle increment
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count_r <= '0;
        end else if (wr_cnt) begin
            count_r <= reg_wdata[CNT_W-1:0];
        end else begin
            count_r <= count_r + {{(CNT_W-1){1'b0}}, inc};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            temp_prev_r <= 1'b0;
        end else begin
            temp_prev_r <= temp_above_trip;
        end
    end

    // Free-running millisecond sampler for the recovery check
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tick_cnt_r <= '0;
            ms_tick_r  <= 1'b0;
        end else if (tick_cnt_r == TICK_W'(SAMPLE_CYCLES - 1)) begin
            tick_cnt_r <= '0;
            ms_tick_r  <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + TICK_W'(1);
            ms_tick_r  <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            th_state_r <= TH_NORMAL;
        end else begin
            unique case (th_state_r)
                TH_NORMAL: begin
                    if (trip_rise) begin
                        th_state_r <= TH_THROTTLE;
                    end
                end
                TH_THROTTLE: begin
                    if (ms_tick_r && !temp_above_trip) begin
                        th_state_r <= TH_NORMAL;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            throttle_req <= 1'b0;
        end else begin
            throttle_req <= (th_state_r == TH_THROTTLE);
        end
    end

    always_comb begin
        rdata_nxt = 32'h0;
        if (reg_rd) begin
            unique case (reg_addr)
                `OFS_EVT_SEL: rdata_nxt = evt_sel_r;
                `OFS_COUNT:   rdata_nxt = 32'(count_r);
                `OFS_STATUS: begin
                    rdata_nxt[`STAT_THROTTLE_BIT] = (th_state_r == TH_THROTTLE);
                    rdata_nxt[`STAT_TEMP_BIT]     = temp_above_trip;
                end
                default:      rdata_nxt = 32'h0;
            endcase
        end
    end

    // Read data stand for exactly the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= rdata_nxt;
        end
    end

    wire logic quiet = !wr_cnt && sel_en;

    a_trip_counts: assert property (@(posedge clk_sys) disable iff (rst)
        quiet && sel_code == `EVT_THERMAL_TRIP && temp_above_trip && !temp_prev_r
        |=> count_r == $past(count_r) + 1)
        else $error("thermal trip not counted");

    a_throttle_enter: assert property (@(posedge clk_sys) disable iff (rst)
        temp_above_trip && !temp_prev_r |=> ##1 throttle_req)
        else $error("trip did not raise throttle");

    a_throttle_recover: assert property (@(posedge clk_sys) disable iff (rst)
        th_state_r == TH_THROTTLE && !temp_above_trip && ms_tick_r |=> ##1 !throttle_req)
        else $error("throttle not released after cool sample");

    a_throttle_hold: assert property (@(posedge clk_sys) disable iff (rst)
        th_state_r == TH_THROTTLE && !ms_tick_r |=> th_state_r == TH_THROTTLE)
        else $error("throttle released between samples");

    a_core_cycles: assert property (@(posedge clk_sys) disable iff (rst)
        quiet && sel_code == `EVT_UNHALTED && sel_umask == `UM_CORE_CYCLES
        |=> count_r == $past(count_r) + ($past(core_halted) ? 0 : 1))
        else $error("core cycle count wrong");

    a_bus_cycles: assert property (@(posedge clk_sys) disable iff (rst)
        quiet && sel_code == `EVT_UNHALTED && sel_umask == `UM_BUS_CYCLES
        && bus_clk_tick && !core_halted |=> count_r == $past(count_r) + 1)
        else $error("bus cycle not counted");

    a_solo_bus: assert property (@(posedge clk_sys) disable iff (rst)
        quiet && sel_code == `EVT_UNHALTED && sel_umask == `UM_SOLO_BUS && !other_core_halted
        |=> count_r == $past(count_r))
        else $error("solo count moved with other core active");

    a_read_count: assert property (@(posedge clk_sys) disable iff (rst)
        quiet && sel_code == `EVT_L1_READ && l1_read && !l1_locked && state_hit
        |=> count_r == $past(count_r) + 1)
        else $error("cacheable read not counted");

    a_write_lock: assert property (@(posedge clk_sys) disable iff (rst)
        quiet && sel_code == `EVT_L1_WRITE && l1_locked |=> count_r == $past(count_r))
        else $error("locked write counted");

    a_lock_read: assert property (@(posedge clk_sys) disable iff (rst)
        quiet && sel_code == `EVT_L1_LOCK_READ && l1_read && l1_locked && state_hit
        |=> count_r == $past(count_r) + 1)
        else $error("locked read not counted");

    a_no_match: assert property (@(posedge clk_sys) disable iff (rst)
        !wr_cnt && (!sel_en || !state_hit && sel_code == `EVT_L1_READ)
        |=> count_r == $past(count_r))
        else $error("count moved without a match");

    c_trip: cover property (@(posedge clk_sys) disable iff (rst) trip_rise ##[1:3] throttle_req);
    c_recover: cover property (@(posedge clk_sys) disable iff (rst)
        $fell(throttle_req));
    c_solo: cover property (@(posedge clk_sys) disable iff (rst)
        sel_code == `EVT_UNHALTED && sel_umask == `UM_SOLO_BUS && inc);
    c_lock: cover property (@(posedge clk_sys) disable iff (rst)
        sel_code == `EVT_L1_LOCK_READ && inc);

endmodule // core_perf_event_counting

//--- src/perf_pkg.sv
// Types shared by the perf counter
package perf_pkg;
    typedef enum logic [0:0] {
        TH_NORMAL   = 1'b0,
        TH_THROTTLE = 1'b1
    } thermal_state_t;

    typedef logic [3:0] line_state_t;
endpackage

//--- src/perf_regs.svh
// Register offsets, field positions, event codes and timing counts of the perf counter
`ifndef PERF_REGS_SVH
`define PERF_REGS_SVH

`define ADDR_W              8
`define OFS_EVT_SEL         8'h00
`define OFS_COUNT           8'h04
`define OFS_STATUS          8'h08

`define SEL_CODE_LSB        0
`define SEL_UMASK_LSB       8
`define SEL_ENABLE_BIT      16
`define SEL_RESET           32'h0000_0000
`define STAT_THROTTLE_BIT   0
`define STAT_TEMP_BIT       1

`define EVT_THERMAL_TRIP    8'h3b
`define EVT_UNHALTED        8'h3c
`define EVT_L1_READ         8'h40
`define EVT_L1_WRITE        8'h41
`define EVT_L1_LOCK_READ    8'h42
`define UM_CORE_CYCLES      8'h00
`define UM_BUS_CYCLES       8'h01
`define UM_SOLO_BUS         8'h02

`define CLK_PERIOD_NS       8
`define TRIP_SAMPLE_NS      1000000
`define TRIP_SAMPLE_CYCLES  (`TRIP_SAMPLE_NS / `CLK_PERIOD_NS)

`endif

//--- verification/tb_top.sv
// Self-checking bench for the core perf event counter
`timescale 1ns/100ps
`include "perf_regs.svh"

module tb_top;
    import perf_pkg::*;
    localparam int SAMPLE = 20;
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] um;
        logic       en;
        logic       halt;
        logic       oth;
        logic [3:0] tick;
        logic       rd;
        logic       wr;
        logic       lk;
        logic [3:0] ls;
        logic [7:0] exp;
    } row_t;
    // Idle keeps the core halted so no cycle event slips in between rows
    localparam row_t IDLE = '{8'h0,8'h0,1'h0,1'h1,1'h0,4'h0,1'h0,1'h0,1'h0,4'h0,8'h0};
    row_t rows [17] = '{
        '{8'h3c,8'h00,1'h1,1'h0,1'h0,4'h5,1'h0,1'h0,1'h0,4'h0,8'h04},
        '{8'h3c,8'h00,1'h1,1'h1,1'h0,4'hf,1'h0,1'h0,1'h0,4'h0,8'h00},
        '{8'h3c,8'h01,1'h1,1'h0,1'h0,4'h5,1'h0,1'h0,1'h0,4'h0,8'h02},
        '{8'h3c,8'h01,1'h1,1'h1,1'h0,4'hf,1'h0,1'h0,1'h0,4'h0,8'h00},
        '{8'h3c,8'h02,1'h1,1'h0,1'h1,4'h5,1'h0,1'h0,1'h0,4'h0,8'h02},
        '{8'h3c,8'h02,1'h1,1'h0,1'h0,4'hf,1'h0,1'h0,1'h0,4'h0,8'h00},
        '{8'h40,8'h01,1'h1,1'h1,1'h0,4'h0,1'h1,1'h0,1'h0,4'h1,8'h04},
        '{8'h40,8'h01,1'h1,1'h1,1'h0,4'h0,1'h1,1'h0,1'h1,4'h1,8'h00},
        '{8'h40,8'h01,1'h1,1'h1,1'h0,4'h0,1'h1,1'h0,1'h0,4'h2,8'h00},
        '{8'h41,8'h08,1'h1,1'h1,1'h0,4'h0,1'h0,1'h1,1'h0,4'h8,8'h04},
        '{8'h41,8'h08,1'h1,1'h1,1'h0,4'h0,1'h0,1'h1,1'h1,4'h8,8'h00},
        '{8'h42,8'h04,1'h1,1'h1,1'h0,4'h0,1'h1,1'h0,1'h1,4'h4,8'h04},
        '{8'h42,8'h04,1'h1,1'h1,1'h0,4'h0,1'h1,1'h0,1'h0,4'h4,8'h00},
        '{8'h40,8'h0f,1'h1,1'h1,1'h0,4'h0,1'h0,1'h1,1'h0,4'hf,8'h00},
        '{8'h3c,8'h00,1'h0,1'h0,1'h0,4'hf,1'h0,1'h0,1'h0,4'h0,8'h00},
        '{8'h3c,8'h03,1'h1,1'h0,1'h1,4'hf,1'h0,1'h0,1'h0,4'h0,8'h00},
        '{8'h43,8'h0f,1'h1,1'h0,1'h1,4'hf,1'h1,1'h1,1'h0,4'hf,8'h00}};
    logic             clk_sys = 1'h0;
    logic             rst = 1'h1;
    logic [7:0]       reg_addr = 8'h00;
    logic [31:0]      reg_wdata = 32'h0;
    logic             reg_wr = 1'h0;
    logic             reg_rd = 1'h0;
    logic [31:0]      reg_rdata;
    logic             temp_above_trip = 1'h0;
    logic             core_halted = 1'h1;
    logic             other_core_halted = 1'h0;
    logic             bus_clk_tick = 1'h0;
    logic             l1_read = 1'h0;
    logic             l1_write = 1'h0;
    logic             l1_locked = 1'h0;
    line_state_t      l1_line_state = 4'h0;
    logic             throttle_req;
    int               errors = 0;
    int               checks = 0;
    int               cycles = 0;
    int               n;

    core_perf_event_counting #(.SAMPLE_CYCLES(SAMPLE)) i_dut (.clk_sys, .rst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .temp_above_trip, .core_halted,
        .other_core_halted, .bus_clk_tick, .l1_read, .l1_write, .l1_locked, .l1_line_state,
        .throttle_req);

    always #4 clk_sys = ~clk_sys;

    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Run is a few hundred cycles; anything near this ceiling is a hang
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            $display("ERROR %0t: timeout", $time);
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Strobes are released for a full cycle so no signal is driven twice per step
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
        @(posedge clk_sys);
    endtask

    task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        @(negedge clk_sys);
        chk(reg_rdata, e);
        @(posedge clk_sys);
    endtask

    task automatic drive(input row_t r, input int i);
        core_halted <= r.halt;
        other_core_halted <= r.oth;
        bus_clk_tick <= r.tick[i];
        l1_read <= r.rd;
        l1_write <= r.wr;
        l1_locked <= r.lk;
        l1_line_state <= r.ls;
    endtask

    task automatic run_row(input row_t r, input logic [31:0] ld);
        bus_wr(`OFS_COUNT, ld);
        bus_wr(`OFS_EVT_SEL, {15'h0, r.en, r.um, r.code});
        for (int i = 0; i < 4; i++) begin
            drive(r, i);
            @(posedge clk_sys);
        end
        drive(IDLE, 0);
        bus_rd(`OFS_COUNT, ld + {24'h0, r.exp});
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'h0;
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk({31'h0, throttle_req}, 32'h0);
        // Bus requests start just after a rising edge, never from a falling one
        @(posedge clk_sys);
        bus_rd(`OFS_EVT_SEL, `SEL_RESET);
        bus_rd(`OFS_COUNT, 32'h0);
        bus_rd(`OFS_STATUS, 32'h0);
        bus_rd(8'h0c, 32'h0);
        $display("reset test done");
        foreach (rows[k]) begin
            run_row(rows[k], 32'h0);
            $display("row %0d done", k);
        end
        run_row(rows[0], 32'hffff_fffe);
        bus_rd(`OFS_EVT_SEL, 32'h0001_003c);
        // Read data must drop back to zero once its single cycle is over
        @(negedge clk_sys);
        chk(reg_rdata, 32'h0);
        @(posedge clk_sys);
        $display("wrap test done");
        bus_wr(`OFS_COUNT, 32'h0);
        bus_wr(`OFS_EVT_SEL, {15'h0, 1'h1, 8'h00, `EVT_THERMAL_TRIP});
        temp_above_trip <= 1'h1;
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk({31'h0, throttle_req}, 32'h0);
        @(negedge clk_sys);
        chk({31'h0, throttle_req}, 32'h1);
        repeat (10) @(posedge clk_sys);
        // Short dip then a second rise: a fresh trip whether or not a tick lands here
        temp_above_trip <= 1'h0;
        @(posedge clk_sys);
        temp_above_trip <= 1'h1;
        repeat (2 * SAMPLE) @(posedge clk_sys);
        bus_rd(`OFS_STATUS, 32'h3);
        bus_rd(`OFS_COUNT, 32'h2);
        temp_above_trip <= 1'h0;
        n = 0;
        while (throttle_req !== 1'h0 && n < SAMPLE + 4) begin
            @(negedge clk_sys);
            n++;
        end
        chk({31'h0, n <= SAMPLE + 3}, 32'h1);
        @(posedge clk_sys);
        bus_rd(`OFS_STATUS, 32'h0);
        $display("thermal test done");
        // Reset in mid-run while throttled must clear count, select and throttle
        bus_wr(`OFS_COUNT, 32'h5);
        temp_above_trip <= 1'h1;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk({31'h0, throttle_req}, 32'h1);
        @(posedge clk_sys);
        rst <= 1'h1;
        temp_above_trip <= 1'h0;
        repeat (2) @(posedge clk_sys);
        rst <= 1'h0;
        @(posedge clk_sys);
        @(negedge clk_sys);
        chk({31'h0, throttle_req}, 32'h0);
        @(posedge clk_sys);
        bus_rd(`OFS_COUNT, 32'h0);
        bus_rd(`OFS_EVT_SEL, `SEL_RESET);
        $display("mid-run reset test done");
        wrap_up();
    end
endmodule // tb_top
